// file: pkg/sse_consts.svh
`ifndef SSE_CONSTS_SVH
`define SSE_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (word aligned byte addresses)
// ----------------------------------------------------------------
`define SSE_OFF_CTRL 8'h00
`define SSE_OFF_STATUS 8'h04
`define SSE_OFF_ACC 8'h08
`define SSE_OFF_WDOG 8'h0C
`define SSE_OFF_FILE 8'h40
// Control fields
`define SSE_CTRL_GO 12
`define SSE_CTRL_OPC_MSB 11
// Status field positions
`define SSE_ST_C 0
`define SSE_ST_DC 1
`define SSE_ST_Z 2
`define SSE_ST_PWRDN 3
`define SSE_ST_EXPIRY 4
`define SSE_ST_WAKE 7
// Opcodes and masks
`define SSE_OPC_SLEEP 12'h003
`define SSE_OPC_SWAP 12'h380
`define SSE_OPC_SUB 12'h080
`define SSE_OPC_MASK 12'hFC0
// Reset values
`define SSE_STATUS_RST 8'h18
`define SSE_WDOG_RST 8'h00
`define SSE_PRE_RST 8'h00
`endif

// file: pkg/sse_pkg.sv
package sse_pkg;
   typedef enum logic [1:0] {SSE_OP_NONE, SSE_OP_SLEEP, SSE_OP_SWAP, SSE_OP_SUB} sse_op_t;
   typedef enum {SSE_IDLE, SSE_ACK} sse_bus_t;
endpackage

// file: rtl/sse_alu.sv
`timescale 1ns/10ps
`include "sse_consts.svh"
// Combinational datapath for the decoded operation
module sse_alu
  (
   input wire sse_pkg::sse_op_t op_i,
   input wire logic [7:0] file_i,
   input wire logic [7:0] acc_i,
   output logic [7:0] res_o,
   output logic c_o,
   output logic dc_o,
   output logic z_o
   );
   import sse_pkg::*;
   logic [8:0] diff;
   logic [4:0] ldiff;
   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   // Two's complement subtract; carry means no borrow
   assign diff = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001;
   assign ldiff = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
   always_comb
   begin
      res_o = file_i;
      c_o = diff[8];
      dc_o = ldiff[4];
      z_o = (diff[7:0] == 8'h00);
      case (op_i)
         SSE_OP_SWAP: res_o = {file_i[3:0], file_i[7:4]};
         SSE_OP_SUB: res_o = diff[7:0];
         default: res_o = file_i;
      endcase
   end
endmodule

// file: rtl/sse_core.sv
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`include "sse_consts.svh"
// Executes one 12-bit opcode per Wishbone write to the control word with the go bit set
module sse_core
  #(
   parameter int FILE_DEPTH = 32
   )
  (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wake_sleep_o,
   output logic [7:0] watchdog_counter_o
   );
   import sse_pkg::*;
   logic [7:0] acc_r;
   logic [7:0] status_r;
   logic [7:0] watchdog_counter_r;
   logic [7:0] wdog_pre_r;
   logic [7:0] file_r [FILE_DEPTH];
   logic wb_ack_r;
   logic [31:0] wb_dat_r;
   logic sleep_r;
   logic [11:0] opc;
   logic [4:0] fadr;
   logic dbit;
   logic go;
   sse_op_t op;
   logic [7:0] res;
   logic alu_c;
   logic alu_dc;
   logic alu_z;
   logic wr;
   logic [4:0] widx;
   logic [31:0] rd_nxt;
   logic [7:0] foff;
   logic fsel;
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // A write takes effect at the edge where the master samples ack high
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r;
   // File window starts at its own offset; index counts words from there
   assign foff = wb_adr_i - `SSE_OFF_FILE;
   assign widx = foff[6:2];
   assign fsel = (wb_adr_i >= `SSE_OFF_FILE) && (foff[7:2] < FILE_DEPTH);
   assign go = wr && wb_sel_i[1] && (wb_adr_i == `SSE_OFF_CTRL) && wb_dat_i[`SSE_CTRL_GO];
   assign opc = wb_dat_i[`SSE_CTRL_OPC_MSB:0];
   assign fadr = opc[4:0];
   assign dbit = opc[5];
   // Opcode decode
   always_comb
   begin
      if (opc == `SSE_OPC_SLEEP)
         op = SSE_OP_SLEEP;
      else if ((opc & `SSE_OPC_MASK) == `SSE_OPC_SWAP)
         op = SSE_OP_SWAP;
      else if ((opc & `SSE_OPC_MASK) == `SSE_OPC_SUB)
         op = SSE_OP_SUB;
      else
         op = SSE_OP_NONE;
   end
   sse_alu u_alu
     (
      .op_i(op),
      .file_i(file_r[fadr]),
      .acc_i(acc_r),
      .res_o(res),
      .c_o(alu_c),
      .dc_o(alu_dc),
      .z_o(alu_z)
      );
   // ----------------------------------------------------------------
   // Handshake
   // ----------------------------------------------------------------
   // Ack one cycle after the strobe, dropped the next cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         wb_ack_r <= 1'b0;
      else
         wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
   end
   // Read mux; unmapped reads return zero
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      if (wb_adr_i == `SSE_OFF_STATUS)
         rd_nxt = {24'h00_0000, status_r};
      else if (wb_adr_i == `SSE_OFF_ACC)
         rd_nxt = {24'h00_0000, acc_r};
      else if (wb_adr_i == `SSE_OFF_WDOG)
         rd_nxt = {16'h0000, wdog_pre_r, watchdog_counter_r};
      else if (fsel)
         rd_nxt = {24'h00_0000, file_r[widx]};
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         wb_dat_r <= 32'h0000_0000;
      else
         wb_dat_r <= rd_nxt;
   end
   // ----------------------------------------------------------------
   // Accumulator and file registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         acc_r <= 8'h00;
      else if (wr && wb_sel_i[0] && wb_adr_i == `SSE_OFF_ACC)
         acc_r <= wb_dat_i[7:0];
      else if (go && (op == SSE_OP_SWAP || op == SSE_OP_SUB) && !dbit)
         acc_r <= res;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (go && (op == SSE_OP_SWAP || op == SSE_OP_SUB) && dbit)
         file_r[fadr] <= res;
      else if (wr && wb_sel_i[0] && fsel)
         file_r[widx] <= wb_dat_i[7:0];
   end
   // ----------------------------------------------------------------
   // Status flags and watchdog
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         status_r <= `SSE_STATUS_RST;
      else if (go && op == SSE_OP_SLEEP)
      begin
         status_r[`SSE_ST_EXPIRY] <= 1'b1;
         status_r[`SSE_ST_PWRDN] <= 1'b0;
      end
      else if (go && op == SSE_OP_SUB)
      begin
         status_r[`SSE_ST_C] <= alu_c;
         status_r[`SSE_ST_DC] <= alu_dc;
         status_r[`SSE_ST_Z] <= alu_z;
      end
      else if (wr && wb_sel_i[0] && wb_adr_i == `SSE_OFF_STATUS)
         status_r <= wb_dat_i[7:0];
   end
   // Watchdog prescaler counts each cycle outside sleep; the counter steps once every 256 cycles
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         watchdog_counter_r <= `SSE_WDOG_RST;
         wdog_pre_r <= `SSE_PRE_RST;
      end
      else if (go && op == SSE_OP_SLEEP)
      begin
         watchdog_counter_r <= 8'h00;
         wdog_pre_r <= 8'h00;
      end
      else if (!sleep_r)
      begin
         wdog_pre_r <= wdog_pre_r + 8'h01;
         if (wdog_pre_r == 8'hFF)
            watchdog_counter_r <= watchdog_counter_r + 8'h01;
      end
   end
   // Sleep request held until status is rewritten by software
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
         sleep_r <= 1'b0;
      else if (go && op == SSE_OP_SLEEP)
         sleep_r <= 1'b1;
      else if (wr && wb_adr_i == `SSE_OFF_STATUS)
         sleep_r <= 1'b0;
   end
   assign wb_ack_o = wb_ack_r;
   assign wb_dat_o = wb_dat_r;
   assign wake_sleep_o = sleep_r;
   assign watchdog_counter_o = watchdog_counter_r;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_sleep_wdog_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SLEEP) |=> (watchdog_counter_r == 8'h00 && wdog_pre_r == 8'h00))
      else $error("watchdog not cleared by sleep");
   chk_sleep_expiry_set: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SLEEP) |=> status_r[`SSE_ST_EXPIRY])
      else $error("expiry flag not set");
   chk_sleep_pwrdn_wake: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SLEEP) |=> (!status_r[`SSE_ST_PWRDN]
      && status_r[`SSE_ST_WAKE] == $past(status_r[`SSE_ST_WAKE])))
      else $error("powerdown or wake flag wrong");
   chk_swap_no_flags: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SWAP) |=> $stable(status_r))
      else $error("swap touched status");
   chk_swap_to_acc: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SWAP && !dbit) |=>
      (acc_r == {$past(file_r[fadr][3:0]), $past(file_r[fadr][7:4])}))
      else $error("swap result not in accumulator");
   chk_swap_to_file: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SWAP && dbit) |=> $stable(acc_r))
      else $error("swap to file changed accumulator");
   chk_swap_file_data: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SWAP && dbit) |=>
      (file_r[$past(fadr)] == {$past(file_r[fadr][3:0]), $past(file_r[fadr][7:4])}))
      else $error("swap result not in file register");
   chk_sub_digit: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SUB) |=>
      (status_r[`SSE_ST_DC] == ($past(file_r[fadr][3:0]) >= $past(acc_r[3:0]))))
      else $error("subtract digit carry wrong");
   chk_sub_carry: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SUB) |=>
      (status_r[`SSE_ST_C] == ($past(file_r[fadr]) >= $past(acc_r))))
      else $error("subtract carry wrong");
   chk_sub_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (go && op == SSE_OP_SUB && !dbit) |=>
      (status_r[`SSE_ST_Z] == (acc_r == 8'h00)))
      else $error("subtract zero flag wrong");
   chk_ack_pulse: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wb_ack_r |=> !wb_ack_r)
      else $error("ack held two cycles");
endmodule

// file: verification/tb_top.sv
`timescale 1ns/10ps
`include "sse_consts.svh"
module tb_top;
   import sse_pkg::*;
   logic sys_clk_i;
   logic srst_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic wake_sleep_o;
   logic [7:0] watchdog_counter_o;
   int err_total;
   int total_checks;
   logic [31:0] rd;
   logic [7:0] fv;
   logic [7:0] av;
   logic [7:0] cf [3] = '{8'h03, 8'h02, 8'h01};

   sse_core i_sse_core (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .wake_sleep_o(wake_sleep_o), .watchdog_counter_o(watchdog_counter_o));

   // ----------------------------------------
   // Clock, watchdog and closing
   // ----------------------------------------
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   initial
   begin
      #(20000 * 100);
      err_total++;
      test_done();
   end

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Bus cycle, compare and expectation helpers
   // ----------------------------------------
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] swp(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction

   // Runs one subtract or exchange and checks both places and the flags
   task automatic run_op(input logic sb, input logic d, input logic [4:0] fa,
                         input logic [7:0] f, input logic [7:0] a);
      logic [7:0] st;
      logic [7:0] res;
      logic [7:0] fadr;
      fadr = `SSE_OFF_FILE + {1'b0, fa, 2'b00};
      wb(1'b1, fadr, {24'h0000_00, f});
      wb(1'b1, `SSE_OFF_ACC, {24'h0000_00, a});
      wb(1'b0, `SSE_OFF_STATUS, 32'h0000_0000);
      st = rd[7:0];
      wb(1'b1, `SSE_OFF_CTRL, {19'h0_0000, 1'b1, sb ? 4'h0 : 4'h3, 2'b10, d, fa});
      res = sb ? f - a : swp(f);
      if (sb)
      begin
         st[2:0] = {res == 8'h00, f[3:0] >= a[3:0], f >= a};
      end
      wb(1'b0, `SSE_OFF_ACC, 32'h0000_0000);
      chk(rd[7:0], d ? a : res);
      wb(1'b0, fadr, 32'h0000_0000);
      chk(rd[7:0], d ? res : f);
      wb(1'b0, `SSE_OFF_STATUS, 32'h0000_0000);
      chk(rd[7:0], st);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      err_total = 0;
      total_checks = 0;
      srst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0000_0000;
      void'($urandom(640));
      repeat (20) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      wb(1'b0, `SSE_OFF_STATUS, 32'h0000_0000);
      chk(rd[7:0], `SSE_STATUS_RST);
      wb(1'b0, 8'h20, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // Byte lane zero disabled: the accumulator write is ignored
      wb(1'b1, `SSE_OFF_ACC, 32'h0000_005A);
      wb_sel_i <= 4'hE;
      wb(1'b1, `SSE_OFF_ACC, 32'h0000_00FF);
      wb_sel_i <= 4'hF;
      wb(1'b0, `SSE_OFF_ACC, 32'h0000_0000);
      chk(rd[7:0], 8'h5A);
      // Borrow corners, then exchange with both nibbles distinct
      foreach (cf[i]) run_op(1'b1, i[0], 5'(i), cf[i], 8'h02);
      run_op(1'b1, 1'b0, 5'h1F, 8'h10, 8'h01);
      run_op(1'b0, 1'b0, 5'h00, 8'hA5, 8'h3C);
      run_op(1'b0, 1'b1, 5'h1F, 8'hA5, 8'h3C);
      repeat (24)
      begin
         fv = 8'($urandom);
         av = 8'($urandom);
         run_op(1'($urandom), 1'($urandom), 5'($urandom), fv, av);
      end
      // Sleep entry with the wake flag set beforehand
      wb(1'b1, `SSE_OFF_STATUS, 32'h0000_008D);
      repeat (600) @(posedge sys_clk_i);
      chk(watchdog_counter_o !== 8'h00, 1'b1);
      wb(1'b1, `SSE_OFF_CTRL, {19'h0_0000, 1'b1, `SSE_OPC_SLEEP});
      @(negedge sys_clk_i);
      chk(watchdog_counter_o, 8'h00);
      chk(wake_sleep_o, 1'b1);
      wb(1'b0, `SSE_OFF_WDOG, 32'h0000_0000);
      chk(rd[15:0], 16'h0000);
      wb(1'b0, `SSE_OFF_STATUS, 32'h0000_0000);
      chk(rd[7:0], 8'h95);
      wb(1'b1, `SSE_OFF_STATUS, 32'h0000_0000);
      @(negedge sys_clk_i);
      chk(wake_sleep_o, 1'b0);
      wb(1'b1, `SSE_OFF_CTRL, {19'h0_0000, 1'b1, `SSE_OPC_SLEEP});
      wb(1'b0, `SSE_OFF_STATUS, 32'h0000_0000);
      chk(rd[7:0], 8'h10);
      test_done();
   end
endmodule
